// >>> dual_timer.sv
`timescale 1ns/1ps
module dual_timer
   import timer_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic count_pin_a,
   input wire logic count_pin_b,
   input wire logic ext_irq_pin_a_n,
   input wire logic ext_irq_pin_b_n,
   input wire logic timer_vector_a,
   input wire logic timer_vector_b,
   input wire logic ext_vector_a,
   input wire logic ext_vector_b,
   output logic overflow_flag_a,
   output logic overflow_flag_b,
   output logic ext_irq_detect_a,
   output logic ext_irq_detect_b
);

   // ----------------------------------------
   // one count step: {overflow, high, low}
   // ----------------------------------------
   function automatic logic [16:0] tstep(input tmode_t m, input logic [7:0] lo,
                                         input logic [7:0] hi);
      logic [8:0] l9;
      logic [5:0] p6;
      logic [8:0] h9;
      logic [16:0] r;
      l9 = {1'b0, lo} + 9'h001;
      p6 = {1'b0, lo[4:0]} + 6'h01;
      h9 = {1'b0, hi} + {8'h00, p6[5]};
      r = {1'b0, hi, lo} + 17'h0_0001;
      case (m)
         MODE_13: tstep = {h9[8], h9[7:0], lo[7:5], p6[4:0]};
         MODE_16: tstep = r;
         MODE_RELOAD: tstep = l9[8] ? {1'b1, hi, hi} : {1'b0, hi, l9[7:0]};
         default: tstep = {l9[8], hi, l9[7:0]};
      endcase
   endfunction

   // ----------------------------------------
   // pin synchronisers and edge detect
   // ----------------------------------------
   logic [NUM_PINS-1:0] pin_raw;
   logic [NUM_PINS-1:0] pin_q;
   logic [NUM_PINS-1:0] prev_q;
   logic [NUM_PINS-1:0] pin_fall;

   assign pin_raw = {ext_irq_pin_b_n, ext_irq_pin_a_n, count_pin_b, count_pin_a};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
         logic meta_bit_q;
         logic sync_bit_q;
         logic prev_bit_q;
         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               meta_bit_q <= 1'b1;
               sync_bit_q <= 1'b1;
               prev_bit_q <= 1'b1;
            end else begin
               meta_bit_q <= pin_raw[gi];
               sync_bit_q <= meta_bit_q;
               prev_bit_q <= sync_bit_q;
            end
         end
         assign pin_q[gi] = sync_bit_q;
         assign prev_q[gi] = prev_bit_q;
         assign pin_fall[gi] = prev_bit_q & ~sync_bit_q;
      end
   endgenerate

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] tctrl_q, tctrl_d;
   logic [7:0] tmode_q;
   logic [7:0] clksel_q;
   logic [7:0] a_lo_q, a_lo_d, a_hi_q, a_hi_d;
   logic [7:0] b_lo_q, b_lo_d, b_hi_q, b_hi_d;
   logic [3:0] div_q, div_d;
   logic [7:0] rdata_q;

   wire wr_tctrl = reg_wr && reg_addr == ADDR_TCTRL;
   wire wr_tmode = reg_wr && reg_addr == ADDR_TMODE;
   wire wr_clksel = reg_wr && reg_addr == ADDR_CLKSEL;
   wire wr_a_lo = reg_wr && reg_addr == ADDR_A_LO;
   wire wr_a_hi = reg_wr && reg_addr == ADDR_A_HI;
   wire wr_b_lo = reg_wr && reg_addr == ADDR_B_LO;
   wire wr_b_hi = reg_wr && reg_addr == ADDR_B_HI;

   // ----------------------------------------
   // internal clock ticks
   // ----------------------------------------
   wire tick_slow = div_q == DIV_SLOW_LAST;
   wire tick_fast = div_q[1:0] == DIV_FAST_LAST;
   assign div_d = tick_slow ? 4'h0 : div_q + 4'h1;

   wire int_tick_a = clksel_q[CDIV_A] ? tick_fast : tick_slow;
   wire int_tick_b = clksel_q[CDIV_B] ? tick_fast : tick_slow;

   // ----------------------------------------
   // count enables
   // ----------------------------------------
   tmode_t mode_a, mode_b;
   assign mode_a = tmode_t'(tmode_q[MODE_A_HI:MODE_A_LO]);
   assign mode_b = tmode_t'(tmode_q[MODE_B_HI:MODE_B_LO]);

   wire src_a = tmode_q[SRC_A] ? pin_fall[PIN_CNT_A] : int_tick_a;
   wire src_b = tmode_q[SRC_B] ? pin_fall[PIN_CNT_B] : int_tick_b;
   wire open_a = ~tmode_q[GATE_A] | pin_q[PIN_IRQ_A];
   wire open_b = ~tmode_q[GATE_B] | pin_q[PIN_IRQ_B];
   wire inc_a = tctrl_q[RUN_A] & open_a & src_a;
   wire inc_b = tctrl_q[RUN_B] & open_b & src_b & (mode_b != MODE_SPLIT);
   wire split_a = mode_a == MODE_SPLIT;
   wire inc_a_hi3 = split_a & tctrl_q[RUN_B] & int_tick_a;

   wire [16:0] step_a = tstep(mode_a, a_lo_q, a_hi_q);
   wire [16:0] step_b = tstep(mode_b, b_lo_q, b_hi_q);
   wire [8:0] a_hi_inc = {1'b0, a_hi_q} + 9'h001;

   wire ovf_a_set = inc_a & step_a[16];
   wire ovf_b_set = split_a ? (inc_a_hi3 & a_hi_inc[8]) : (inc_b & step_b[16]);

   // ----------------------------------------
   // count next values, write wins over count
   // ----------------------------------------
   assign a_lo_d = wr_a_lo ? reg_wdata : (inc_a ? step_a[7:0] : a_lo_q);
   assign a_hi_d = wr_a_hi ? reg_wdata :
                   split_a ? (inc_a_hi3 ? a_hi_inc[7:0] : a_hi_q) :
                   (inc_a ? step_a[15:8] : a_hi_q);
   assign b_lo_d = wr_b_lo ? reg_wdata : (inc_b ? step_b[7:0] : b_lo_q);
   assign b_hi_d = wr_b_hi ? reg_wdata : (inc_b ? step_b[15:8] : b_hi_q);

   // ----------------------------------------
   // control flags, hardware set beats clear
   // ----------------------------------------
   wire det_set_a = tctrl_q[TYPE_A] & pin_fall[PIN_IRQ_A];
   wire det_set_b = tctrl_q[TYPE_B] & pin_fall[PIN_IRQ_B];

   function automatic logic flag_next(input logic set, input logic wr, input logic wbit,
                                      input logic clr, input logic cur);
      flag_next = set | (wr ? wbit : (~clr & cur));
   endfunction

   always_comb begin
      tctrl_d = wr_tctrl ? reg_wdata : tctrl_q;
      tctrl_d[OVF_B] = flag_next(ovf_b_set, wr_tctrl, reg_wdata[OVF_B], timer_vector_b,
                                 tctrl_q[OVF_B]);
      tctrl_d[OVF_A] = flag_next(ovf_a_set, wr_tctrl, reg_wdata[OVF_A], timer_vector_a,
                                 tctrl_q[OVF_A]);
      tctrl_d[DET_A] = tctrl_q[TYPE_A] ?
                       flag_next(det_set_a, wr_tctrl, reg_wdata[DET_A], ext_vector_a,
                                 tctrl_q[DET_A]) : ~pin_q[PIN_IRQ_A];
      tctrl_d[DET_B] = tctrl_q[TYPE_B] ?
                       flag_next(det_set_b, wr_tctrl, reg_wdata[DET_B], ext_vector_b,
                                 tctrl_q[DET_B]) : ~pin_q[PIN_IRQ_B];
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   logic [7:0] rd_mux;
   always_comb begin
      case (reg_addr)
         ADDR_TCTRL: rd_mux = tctrl_q;
         ADDR_TMODE: rd_mux = tmode_q;
         ADDR_A_LO: rd_mux = a_lo_q;
         ADDR_A_HI: rd_mux = a_hi_q;
         ADDR_B_LO: rd_mux = b_lo_q;
         ADDR_B_HI: rd_mux = b_hi_q;
         ADDR_CLKSEL: rd_mux = clksel_q;
         default: rd_mux = RST_BYTE;
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tctrl_q <= RST_BYTE;
         tmode_q <= RST_BYTE;
         clksel_q <= RST_BYTE;
         a_lo_q <= RST_BYTE;
         a_hi_q <= RST_BYTE;
         b_lo_q <= RST_BYTE;
         b_hi_q <= RST_BYTE;
         div_q <= 4'h0;
         rdata_q <= RST_BYTE;
      end else begin
         tctrl_q <= tctrl_d;
         tmode_q <= wr_tmode ? reg_wdata : tmode_q;
         clksel_q <= wr_clksel ? (reg_wdata & CLKSEL_MASK) : clksel_q;
         a_lo_q <= a_lo_d;
         a_hi_q <= a_hi_d;
         b_lo_q <= b_lo_d;
         b_hi_q <= b_hi_d;
         div_q <= div_d;
         rdata_q <= reg_rd ? rd_mux : RST_BYTE;
      end
   end

   assign reg_rdata = rdata_q;
   assign overflow_flag_a = tctrl_q[OVF_A];
   assign overflow_flag_b = tctrl_q[OVF_B];
   assign ext_irq_detect_a = tctrl_q[DET_A];
   assign ext_irq_detect_b = tctrl_q[DET_B];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   sequence s_no_clr_a;
      !wr_tctrl && !timer_vector_a;
   endsequence

   property p_ovf_a;
      inc_a && step_a[16] |=> overflow_flag_a;
   endproperty
   a_ovf_a: assert property (p_ovf_a) else $error("flag A not set on overflow");

   property p_ovf_b;
      ovf_b_set |=> overflow_flag_b;
   endproperty
   a_ovf_b: assert property (p_ovf_b) else $error("flag B not set on overflow");

   property p_vec_clr_a;
      timer_vector_a && !wr_tctrl && !ovf_a_set |=> !overflow_flag_a;
   endproperty
   a_vec_clr_a: assert property (p_vec_clr_a) else $error("vector did not clear A");

   property p_flag_hold_a;
      overflow_flag_a ##0 s_no_clr_a |=> overflow_flag_a;
   endproperty
   a_flag_hold_a: assert property (p_flag_hold_a) else $error("flag A lost");

   property p_halt_a;
      !tctrl_q[RUN_A] && !split_a && !wr_a_lo && !wr_a_hi |=> $stable(a_lo_q) && $stable(a_hi_q);
   endproperty
   a_halt_a: assert property (p_halt_a) else $error("halted timer A moved");

   property p_edge_det_a;
      tctrl_q[TYPE_A] && pin_fall[PIN_IRQ_A] |=> ext_irq_detect_a;
   endproperty
   a_edge_det_a: assert property (p_edge_det_a) else $error("edge not caught");

   property p_level_a;
      !tctrl_d[TYPE_A] && !tctrl_q[TYPE_A] |=> ext_irq_detect_a == !$past(pin_q[PIN_IRQ_A]);
   endproperty
   a_level_a: assert property (p_level_a) else $error("level detect wrong");

   property p_gate_a;
      tmode_q[GATE_A] && !pin_q[PIN_IRQ_A] && !wr_a_lo && !wr_a_hi && !split_a
         |=> $stable(a_lo_q);
   endproperty
   a_gate_a: assert property (p_gate_a) else $error("gated timer counted");

   property p_mode13;
      inc_a && mode_a == MODE_13 && a_lo_q[4:0] == 5'h1f && !wr_a_lo && !wr_a_hi
         |=> a_lo_q[4:0] == 5'h00 && a_hi_q == $past(a_hi_q) + 8'h01;
   endproperty
   a_mode13: assert property (p_mode13) else $error("prescale carry wrong");

   property p_reload_a;
      inc_a && mode_a == MODE_RELOAD && a_lo_q == 8'hff && !wr_a_lo
         |=> a_lo_q == $past(a_hi_q) && overflow_flag_a;
   endproperty
   a_reload_a: assert property (p_reload_a) else $error("reload wrong");

   property p_hold_b3;
      mode_b == MODE_SPLIT && !wr_b_lo && !wr_b_hi |=> $stable(b_lo_q) && $stable(b_hi_q);
   endproperty
   a_hold_b3: assert property (p_hold_b3) else $error("timer B moved in mode 3");

   property p_split_hi;
      inc_a_hi3 && a_hi_q == 8'hff && !wr_a_hi |=> a_hi_q == 8'h00 && overflow_flag_b;
   endproperty
   a_split_hi: assert property (p_split_hi) else $error("split high byte wrong");

   property p_div_slow;
      tick_slow |=> !tick_slow [*8];
   endproperty
   a_div_slow: assert property (p_div_slow) else $error("slow tick too often");

   property p_rd_lo;
      reg_rd && reg_addr == ADDR_A_LO |=> reg_rdata == $past(a_lo_q);
   endproperty
   a_rd_lo: assert property (p_rd_lo) else $error("low byte read wrong");

   property p_vec_clr_b;
      timer_vector_b && !wr_tctrl && !ovf_b_set |=> !overflow_flag_b;
   endproperty
   a_vec_clr_b: assert property (p_vec_clr_b) else $error("vector did not clear B");

   property p_halt_b;
      !tctrl_q[RUN_B] && !wr_b_lo && !wr_b_hi |=> $stable(b_lo_q) && $stable(b_hi_q);
   endproperty
   a_halt_b: assert property (p_halt_b) else $error("halted timer B moved");

   sequence s_no_clr_det_a;
      !wr_tctrl && !ext_vector_a;
   endsequence

   property p_edge_hold_a;
      tctrl_q[TYPE_A] && ext_irq_detect_a ##0 s_no_clr_det_a |=> ext_irq_detect_a;
   endproperty
   a_edge_hold_a: assert property (p_edge_hold_a) else $error("edge flag A lost");

   property p_ext_clr_a;
      tctrl_q[TYPE_A] && ext_vector_a && !wr_tctrl && !det_set_a |=> !ext_irq_detect_a;
   endproperty
   a_ext_clr_a: assert property (p_ext_clr_a) else $error("service did not clear A");

   property p_edge_det_b;
      tctrl_q[TYPE_B] && pin_fall[PIN_IRQ_B] |=> ext_irq_detect_b;
   endproperty
   a_edge_det_b: assert property (p_edge_det_b) else $error("edge B not caught");

   property p_level_b;
      !tctrl_d[TYPE_B] && !tctrl_q[TYPE_B] |=> ext_irq_detect_b == !$past(pin_q[PIN_IRQ_B]);
   endproperty
   a_level_b: assert property (p_level_b) else $error("level detect B wrong");

   property p_src_pin_a;
      tmode_q[SRC_A] && !pin_fall[PIN_CNT_A] && !wr_a_lo && !wr_a_hi && !split_a
         |=> $stable(a_lo_q) && $stable(a_hi_q);
   endproperty
   a_src_pin_a: assert property (p_src_pin_a) else $error("counted without pin edge");

   property p_mode16;
      inc_a && mode_a == MODE_16 && !wr_a_lo && !wr_a_hi
         |=> {a_hi_q, a_lo_q} == $past({a_hi_q, a_lo_q}) + 16'h0001;
   endproperty
   a_mode16: assert property (p_mode16) else $error("sixteen bit step wrong");

   property p_split_lo;
      split_a && !inc_a && !wr_a_lo |=> $stable(a_lo_q);
   endproperty
   a_split_lo: assert property (p_split_lo) else $error("split low byte moved");

   property p_div_fast;
      tick_fast |=> !tick_fast [*3] ##1 tick_fast;
   endproperty
   a_div_fast: assert property (p_div_fast) else $error("fast tick period wrong");

endmodule

// >>> dual_timer_counter_ext_irq_tb.sv
`timescale 1ns/1ps
module dual_timer_counter_ext_irq_tb;
   import timer_pkg::*;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic count_pin_a, count_pin_b, ext_irq_pin_a_n, ext_irq_pin_b_n;
   logic timer_vector_a = 1'b0;
   logic timer_vector_b = 1'b0;
   logic ext_vector_a = 1'b0;
   logic ext_vector_b = 1'b0;
   logic overflow_flag_a, overflow_flag_b, ext_irq_detect_a, ext_irq_detect_b;
   int errors = 0;
   int check_count = 0;
   int n;
   logic [7:0] r;
   time t0, t1;

   always #5 mclk = ~mclk;

   pin_partner pins (.mclk(mclk), .count_pin_a(count_pin_a), .count_pin_b(count_pin_b),
      .ext_irq_pin_a_n(ext_irq_pin_a_n), .ext_irq_pin_b_n(ext_irq_pin_b_n));

   dual_timer dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_pin_a(count_pin_a),
      .count_pin_b(count_pin_b), .ext_irq_pin_a_n(ext_irq_pin_a_n),
      .ext_irq_pin_b_n(ext_irq_pin_b_n), .timer_vector_a(timer_vector_a),
      .timer_vector_b(timer_vector_b), .ext_vector_a(ext_vector_a),
      .ext_vector_b(ext_vector_b), .overflow_flag_a(overflow_flag_a),
      .overflow_flag_b(overflow_flag_b), .ext_irq_detect_a(ext_irq_detect_a),
      .ext_irq_detect_b(ext_irq_detect_b));

   // ----------------------------------------
   // compare, bus and closing tasks
   // ----------------------------------------
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk8(nm, e, reg_rdata);
   endtask

   // one-cycle pulse: 0 timer a, 1 timer b, 2 ext a, 3 ext b
   task automatic vec(input int k);
      @(posedge mclk);
      {ext_vector_b, ext_vector_a, timer_vector_b, timer_vector_a} <= 4'(1 << k);
      @(posedge mclk);
      {ext_vector_b, ext_vector_a, timer_vector_b, timer_vector_a} <= 4'h0;
      #1;
   endtask

   task automatic wait_flag(input int b, output time t);
      int i;
      for (i = 0; i < 1000; i++) begin
         if ((b == 1 ? overflow_flag_b : overflow_flag_a) === 1'b1) break;
         @(posedge mclk);
         #1;
      end
      t = $time;
      if (i == 1000) begin
         errors++;
         stop_test();
      end
   endtask

   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      n = $urandom(32'h4871);
      repeat (20) @(posedge mclk);
      arst_n <= 1'b1;
      for (int a = 8'h88; a <= 8'h8f; a++) rdchk("reset", 8'(a), 8'h00);
      r = 8'($urandom);
      wr(ADDR_A_LO, r);
      rdchk("a_lo", ADDR_A_LO, r);
      wr(ADDR_A_HI, ~r);
      rdchk("a_hi", ADDR_A_HI, ~r);
      wr(ADDR_B_LO, r ^ 8'h5a);
      rdchk("b_lo", ADDR_B_LO, r ^ 8'h5a);
      wr(ADDR_B_HI, r + 8'h01);
      rdchk("b_hi", ADDR_B_HI, r + 8'h01);
      wr(8'h8f, r);
      rdchk("unmapped", 8'h8f, 8'h00);
      done("bytes");
      // sixteen-bit wrap, then halt holds count
      wr(ADDR_CLKSEL, 8'h08);
      wr(ADDR_A_LO, 8'hfe);
      wr(ADDR_A_HI, 8'hff);
      wr(ADDR_TMODE, 8'h01);
      wr(ADDR_TCTRL, 8'h10);
      wait_flag(0, t0);
      wr(ADDR_TCTRL, 8'h20);
      rdchk("wrap_lo", ADDR_A_LO, 8'h00);
      rdchk("wrap_hi", ADDR_A_HI, 8'h00);
      repeat (40) @(posedge mclk);
      rdchk("held", ADDR_A_LO, 8'h00);
      vec(0);
      chk1("flag_a", 1'b0, overflow_flag_a);
      done("mode1");
      // auto reload on each timer; flag period shows the divider
      for (int b = 0; b < 2; b++) begin
         wr(ADDR_CLKSEL, b == 1 ? 8'h00 : 8'h08);
         wr(b == 1 ? ADDR_B_HI : ADDR_A_HI, 8'hfe);
         wr(b == 1 ? ADDR_B_LO : ADDR_A_LO, 8'hfd);
         wr(ADDR_TMODE, b == 1 ? 8'h20 : 8'h02);
         wr(ADDR_TCTRL, b == 1 ? 8'h40 : 8'h10);
         wait_flag(b, t0);
         vec(b);
         wait_flag(b, t1);
         chk8("period", 8'((b == 1 ? 12 : 4) * 2), 8'((t1 - t0) / 10));
         wr(ADDR_TCTRL, b == 1 ? 8'h80 : 8'h20);
         rdchk("reload", b == 1 ? ADDR_B_LO : ADDR_A_LO, 8'hfe);
         wr(ADDR_TCTRL, 8'h00);
         #1;
         chk1("sw_clear", 1'b0, b == 1 ? overflow_flag_b : overflow_flag_a);
      end
      done("reload");
      wr(ADDR_B_LO, r);
      wr(ADDR_TMODE, 8'h30);
      wr(ADDR_TCTRL, 8'h40);
      repeat (60) @(posedge mclk);
      wr(ADDR_TCTRL, 8'h00);
      rdchk("b_mode3", ADDR_B_LO, r);
      done("b_halt");
      // prescaled mode 0 wrap on timer A
      wr(ADDR_A_LO, 8'hfd);
      wr(ADDR_A_HI, 8'hff);
      wr(ADDR_TMODE, 8'h00);
      wr(ADDR_TCTRL, 8'h10);
      wait_flag(0, t0);
      wr(ADDR_TCTRL, 8'h20);
      rdchk("pre_lo", ADDR_A_LO, 8'he0);
      rdchk("pre_hi", ADDR_A_HI, 8'h00);
      done("mode0");
      // split mode: high byte runs under run B, low byte held
      wr(ADDR_A_LO, 8'hfe);
      wr(ADDR_A_HI, 8'hfe);
      wr(ADDR_TMODE, 8'h03);
      wr(ADDR_TCTRL, 8'h40);
      wait_flag(1, t0);
      chk1("split_flag_a", 1'b0, overflow_flag_a);
      wr(ADDR_TCTRL, 8'h00);
      rdchk("split_hi", ADDR_A_HI, 8'h00);
      rdchk("split_lo", ADDR_A_LO, 8'hfe);
      done("split");
      // reset with both timers stopped clears the count
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      rdchk("mid_reset", ADDR_A_LO, 8'h00);
      done("mid_reset");
      // external pulses, then gate closed by the interrupt pin
      wr(ADDR_A_LO, 8'h00);
      wr(ADDR_A_HI, 8'h00);
      wr(ADDR_TMODE, 8'h05);
      wr(ADDR_TCTRL, 8'h10);
      n = $urandom_range(20, 1);
      pins.pulse_a(n);
      repeat (6) @(posedge mclk);
      rdchk("pin_count", ADDR_A_LO, 8'(n));
      wr(ADDR_TMODE, 8'h0d);
      pins.set_irq(0, 1'b0);
      pins.pulse_a(3);
      pins.set_irq(0, 1'b1);
      pins.pulse_a(2);
      repeat (6) @(posedge mclk);
      rdchk("gated", ADDR_A_LO, 8'(n + 2));
      wr(ADDR_B_LO, 8'h00);
      wr(ADDR_TMODE, 8'hd0);
      wr(ADDR_TCTRL, 8'h40);
      pins.pulse_b(3);
      pins.set_irq(1, 1'b0);
      pins.pulse_b(2);
      pins.set_irq(1, 1'b1);
      repeat (6) @(posedge mclk);
      rdchk("pin_count_b", ADDR_B_LO, 8'h03);
      wr(ADDR_TCTRL, 8'h00);
      done("counter");
      pins.set_irq(1, 1'b0);
      repeat (5) @(posedge mclk);
      #1;
      chk1("level_low", 1'b1, ext_irq_detect_b);
      pins.set_irq(1, 1'b1);
      repeat (5) @(posedge mclk);
      #1;
      chk1("level_high", 1'b0, ext_irq_detect_b);
      wr(ADDR_TCTRL, 8'h05);
      for (int k = 0; k < 4; k++) begin
         pins.set_irq(k % 2, 1'b0);
         repeat (5) @(posedge mclk);
         pins.set_irq(k % 2, 1'b1);
         repeat (5) @(posedge mclk);
         #1;
         chk1("edge_kept", 1'b1, k % 2 == 1 ? ext_irq_detect_b : ext_irq_detect_a);
         if (k >= 2) begin
            wr(ADDR_TCTRL, 8'h05);
            #1;
         end else begin
            vec(2 + k);
         end
         chk1("edge_clear", 1'b0, k % 2 == 1 ? ext_irq_detect_b : ext_irq_detect_a);
      end
      done("ext_irq");
      stop_test();
   end
endmodule

// >>> pin_partner.sv
`timescale 1ns/1ps
module pin_partner (
   input wire logic mclk,
   output logic count_pin_a,
   output logic count_pin_b,
   output logic ext_irq_pin_a_n,
   output logic ext_irq_pin_b_n
);
   // pins idle high, as with pull-ups
   initial begin
      count_pin_a = 1'b1;
      count_pin_b = 1'b1;
      ext_irq_pin_a_n = 1'b1;
      ext_irq_pin_b_n = 1'b1;
   end

   // each level held three cycles so no pulse is missed
   task automatic pulse_a(input int n);
      repeat (n) begin
         repeat (3) @(posedge mclk);
         count_pin_a <= 1'b0;
         repeat (3) @(posedge mclk);
         count_pin_a <= 1'b1;
      end
   endtask

   task automatic pulse_b(input int n);
      repeat (n) begin
         repeat (3) @(posedge mclk);
         count_pin_b <= 1'b0;
         repeat (3) @(posedge mclk);
         count_pin_b <= 1'b1;
      end
   endtask

   task automatic set_irq(input int b, input logic lvl);
      @(posedge mclk);
      if (b == 1) begin
         ext_irq_pin_b_n <= lvl;
      end else begin
         ext_irq_pin_a_n <= lvl;
      end
   endtask
endmodule

// >>> timer_pkg.sv
package timer_pkg;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_TCTRL = 8'h88;
   localparam logic [7:0] ADDR_TMODE = 8'h89;
   localparam logic [7:0] ADDR_A_LO = 8'h8a;
   localparam logic [7:0] ADDR_B_LO = 8'h8b;
   localparam logic [7:0] ADDR_A_HI = 8'h8c;
   localparam logic [7:0] ADDR_B_HI = 8'h8d;
   localparam logic [7:0] ADDR_CLKSEL = 8'h8e;

   localparam logic [7:0] RST_BYTE = 8'h00;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int OVF_B = 7;
   localparam int RUN_B = 6;
   localparam int OVF_A = 5;
   localparam int RUN_A = 4;
   localparam int DET_B = 3;
   localparam int TYPE_B = 2;
   localparam int DET_A = 1;
   localparam int TYPE_A = 0;

   localparam int GATE_B = 7;
   localparam int SRC_B = 6;
   localparam int MODE_B_HI = 5;
   localparam int MODE_B_LO = 4;
   localparam int GATE_A = 3;
   localparam int SRC_A = 2;
   localparam int MODE_A_HI = 1;
   localparam int MODE_A_LO = 0;

   localparam int CDIV_B = 4;
   localparam int CDIV_A = 3;
   localparam logic [7:0] CLKSEL_MASK = 8'h18;

   // ----------------------------------------
   // internal clock dividers
   // ----------------------------------------
   localparam int DIV_SLOW = 12;
   localparam int DIV_FAST = 4;
   localparam logic [3:0] DIV_SLOW_LAST = 4'(DIV_SLOW - 1);
   localparam logic [1:0] DIV_FAST_LAST = 2'(DIV_FAST - 1);

   // ----------------------------------------
   // pin vector positions
   // ----------------------------------------
   localparam int PIN_CNT_A = 0;
   localparam int PIN_CNT_B = 1;
   localparam int PIN_IRQ_A = 2;
   localparam int PIN_IRQ_B = 3;
   localparam int NUM_PINS = 4;

   typedef enum logic [1:0] {
      MODE_13 = 2'b00,
      MODE_16 = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT = 2'b11
   } tmode_t;

endpackage
